/* File: inc/chg_pkg.sv */
// Purpose: Shared constants and types for the charge sequence state machine
// Assumes: 20 MHz system clock; timer periods given in seconds
// Notes:   Timer lengths default to typical figures with the nominal timer setting
package chg_pkg;

   // System clock rate
   localparam int unsigned CLK_HZ          = 20_000_000;

   // Typical phase durations, in seconds
   localparam int unsigned PREQUAL_TIME_S  = 450;
   localparam int unsigned FAST_TIME_S     = 5400;
   localparam int unsigned FULL_TIME_S     = 5400;
   localparam int unsigned TOPOFF_TIME_S   = 2700;

   // Timers advance on a one-second tick
   localparam int unsigned TICK_TIME_S     = 1;
   localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_TIME_S;
   localparam int unsigned TICK_CNT_W      = 25;
   localparam int unsigned TIMER_W         = 16;

   // Counter reset value
   localparam logic [TIMER_W-1:0] TIMER_RST = 16'h0000;

   // Charge current commands
   typedef enum logic [1:0] {
      CHG_I_OFF     = 2'h0,
      CHG_I_TWENTY  = 2'h1,
      CHG_I_CC      = 2'h2,
      CHG_I_CV      = 2'h3
   } chg_cmd_t;

   // Sequence states, one-hot
   typedef enum logic [7:0] {
      ST_RESET   = 8'h01,
      ST_PREQUAL = 8'h02,
      ST_FAST    = 8'h04,
      ST_FULL    = 8'h08,
      ST_TOPOFF  = 8'h10,
      ST_DONE    = 8'h20,
      ST_FAULT   = 8'h40
   } chg_state_t;

   // Comparator results from the analog side
   typedef struct packed {
      logic supply_ok;
      logic battery_sense_above_uv;
      logic battery_sense_at_reg;
      logic battery_sense_above_ov;
      logic battery_sense_below_rechg;
      logic current_below_tenth;
      logic temp_in_range;
   } chg_sense_t;

   // Status indicators, all active low
   typedef struct packed {
      logic const_current_indicator_n;
      logic const_voltage_indicator_n;
      logic fault_indicator_n;
   } chg_status_t;

endpackage

/* File: logic/chg_seq.sv */
// Purpose: Charge sequence state machine with phase timers and indicators
// Assumes: Sense inputs are asynchronous comparator levels; synchronised here
// Notes:   Open-drain indicators are modelled as levels, low meaning pulled down
`timescale 1ns/100ps

module chg_seq
   import chg_pkg::*;
#(
   parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
   parameter int unsigned PREQUAL_TICKS = PREQUAL_TIME_S / TICK_TIME_S,
   parameter int unsigned FAST_TICKS    = FAST_TIME_S / TICK_TIME_S,
   parameter int unsigned FULL_TICKS    = FULL_TIME_S / TICK_TIME_S,
   parameter int unsigned TOPOFF_TICKS  = TOPOFF_TIME_S / TICK_TIME_S
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        charge_disable_n,
   input  wire chg_sense_t  sense,
   output logic             charge_enable,
   output chg_cmd_t         charge_cmd,
   output chg_status_t      status,
   output chg_state_t       state
);

   // Synchroniser stages for the asynchronous inputs
   logic [7:0]              sync1_ff;
   logic [7:0]              sync2_ff;
   chg_sense_t              sn;
   logic                    enable_s;
   logic                    enable_prev_ff;

   chg_state_t              state_ff;
   chg_state_t              nxt_state;
   logic [TICK_CNT_W-1:0]   tick_cnt_ff;
   logic                    tick;
   logic [TIMER_W-1:0]      phase_timer_a_ff;
   logic [TIMER_W-1:0]      phase_timer_b_ff;
   logic [TIMER_W-1:0]      nxt_timer_a;
   logic [TIMER_W-1:0]      nxt_timer_b;
   logic                    timer_a_done;
   logic                    timer_b_done;
   logic                    temp_ok;
   logic                    release_edge;
   logic                    force_reset;
   logic                    charging_phase;
   logic [TIMER_W-1:0]      timer_a_limit;
   chg_cmd_t                nxt_cmd;
   chg_status_t             nxt_status;

   // Two-flop synchronisers; only the second stage is read
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_ff <= 8'h00;
         sync2_ff <= 8'h00;
      end else begin
         sync1_ff <= {charge_disable_n, sense};
         sync2_ff <= sync1_ff;
      end
   end

   assign enable_s = sync2_ff[7];
   assign sn       = chg_sense_t'(sync2_ff[6:0]);
   assign temp_ok  = sn.temp_in_range;

   // Detect release of the disable input
   always_ff @(posedge clk) begin
      if (rst) begin
         enable_prev_ff <= 1'b0;
      end else begin
         enable_prev_ff <= enable_s;
      end
   end

   assign release_edge = enable_s & ~enable_prev_ff;
   // Disable held low by the controller keeps the machine in reset
   assign force_reset  = ~enable_s | release_edge | sn.battery_sense_above_ov;

   // One-second tick divider
   always_ff @(posedge clk) begin
      if (rst || tick) begin
         tick_cnt_ff <= '0;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 1'b1;
      end
   end

   assign tick = (tick_cnt_ff == TICK_CNT_W'(TICK_CYCLES_P - 1));

   // Limit of the first timer depends on the phase it is timing
   always_comb begin
      unique case (state_ff)
         ST_PREQUAL: timer_a_limit = TIMER_W'(PREQUAL_TICKS);
         ST_FULL:    timer_a_limit = TIMER_W'(FULL_TICKS);
         ST_TOPOFF:  timer_a_limit = TIMER_W'(TOPOFF_TICKS);
         default:    timer_a_limit = TIMER_W'(PREQUAL_TICKS);
      endcase
   end

   assign timer_a_done = (phase_timer_a_ff >= timer_a_limit);
   assign timer_b_done = (phase_timer_b_ff >= TIMER_W'(FAST_TICKS));

   assign charging_phase = (state_ff == ST_FAST) | (state_ff == ST_FULL)
                         | (state_ff == ST_TOPOFF);

   // Next state
   always_comb begin
      nxt_state = state_ff;
      if (force_reset) begin
         nxt_state = ST_RESET;
      end else begin
         unique case (state_ff)
            ST_RESET: begin
               if (sn.supply_ok) begin
                  nxt_state = ST_PREQUAL;
               end
            end
            ST_PREQUAL: begin
               if (sn.battery_sense_above_uv && temp_ok) begin
                  nxt_state = ST_FAST;
               end else if (timer_a_done && !sn.battery_sense_above_uv) begin
                  nxt_state = ST_FAULT;
               end
            end
            ST_FAST: begin
               if (!sn.battery_sense_above_uv) begin
                  nxt_state = ST_PREQUAL;
               end else if (sn.battery_sense_at_reg) begin
                  nxt_state = ST_FULL;
               end else if (timer_b_done) begin
                  nxt_state = ST_FAULT;
               end
            end
            ST_FULL: begin
               if (!sn.battery_sense_above_uv) begin
                  nxt_state = ST_PREQUAL;
               end else if (sn.current_below_tenth || timer_a_done) begin
                  nxt_state = ST_TOPOFF;
               end
            end
            ST_TOPOFF: begin
               if (!sn.battery_sense_above_uv) begin
                  nxt_state = ST_PREQUAL;
               end else if (timer_a_done) begin
                  nxt_state = ST_DONE;
               end
            end
            ST_DONE: begin
               if (sn.battery_sense_below_rechg) begin
                  nxt_state = ST_RESET;
               end
            end
            ST_FAULT: begin
               nxt_state = ST_FAULT;
            end
            default: begin
               nxt_state = ST_RESET;
            end
         endcase
      end
   end

   // Timer updates; a phase change clears the first timer, temperature freezes both
   always_comb begin
      nxt_timer_a = phase_timer_a_ff;
      nxt_timer_b = phase_timer_b_ff;
      if (nxt_state == ST_RESET || state_ff == ST_RESET) begin
         nxt_timer_a = TIMER_RST;
         nxt_timer_b = TIMER_RST;
      end else if (nxt_state != state_ff) begin
         nxt_timer_a = TIMER_RST;
      end else if (tick && temp_ok) begin
         if (state_ff == ST_FAST) begin
            if (!timer_b_done) begin
               nxt_timer_b = phase_timer_b_ff + 1'b1;
            end
         end else if (state_ff == ST_PREQUAL || state_ff == ST_FULL
                      || state_ff == ST_TOPOFF) begin
            if (!timer_a_done) begin
               nxt_timer_a = phase_timer_a_ff + 1'b1;
            end
         end
      end
   end

   // Charge command and indicators from the next state
   always_comb begin
      nxt_cmd    = CHG_I_OFF;
      nxt_status = '{1'b1, 1'b1, 1'b1};
      unique case (nxt_state)
         ST_PREQUAL: begin
            nxt_cmd = temp_ok ? CHG_I_TWENTY : CHG_I_OFF;
            nxt_status.const_current_indicator_n = 1'b0;
         end
         ST_FAST: begin
            nxt_cmd = temp_ok ? CHG_I_CC : CHG_I_OFF;
            nxt_status.const_current_indicator_n = 1'b0;
         end
         ST_FULL: begin
            nxt_cmd = temp_ok ? CHG_I_CV : CHG_I_OFF;
            nxt_status.const_voltage_indicator_n = 1'b0;
         end
         ST_TOPOFF: begin
            nxt_cmd = temp_ok ? CHG_I_CV : CHG_I_OFF;
         end
         ST_FAULT: begin
            nxt_status.fault_indicator_n = 1'b0;
         end
         default: begin
            nxt_cmd = CHG_I_OFF;
         end
      endcase
   end

   // State, timers and registered outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff         <= ST_RESET;
         phase_timer_a_ff <= TIMER_RST;
         phase_timer_b_ff <= TIMER_RST;
         charge_cmd       <= CHG_I_OFF;
         charge_enable    <= 1'b0;
         status           <= '{1'b1, 1'b1, 1'b1};
         state            <= ST_RESET;
      end else begin
         state_ff         <= nxt_state;
         phase_timer_a_ff <= nxt_timer_a;
         phase_timer_b_ff <= nxt_timer_b;
         charge_cmd       <= nxt_cmd;
         charge_enable    <= (nxt_cmd != CHG_I_OFF);
         status           <= nxt_status;
         state            <= nxt_state;
      end
   end

   // Temperature pause is visible as charge_enable low in a charging phase
   logic unused_ok;
   assign unused_ok = charging_phase;

endmodule

/* File: tb/chg_seq_properties.sv */
// Purpose: Checker for the charge sequencer outputs
// Assumes: A sense change reaches the state three edges later
// Notes:   Bound to chg_seq
`timescale 1ns/100ps
module chg_seq_properties
   import chg_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        charge_disable_n,
   input wire chg_sense_t  sense,
   input wire logic        charge_enable,
   input wire chg_cmd_t    charge_cmd,
   input wire chg_status_t status,
   input wire chg_state_t  state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [2:0] quiet_ff;
   logic [2:0] nxt_quiet;
   // Cycles since the last disable or overvoltage, saturating
   assign nxt_quiet = (!charge_disable_n || sense.battery_sense_above_ov) ? 3'h0 :
                      (quiet_ff == 3'h7) ? quiet_ff : quiet_ff + 3'h1;
   always_ff @(posedge clk) quiet_ff <= rst ? 3'h0 : nxt_quiet;
   AST_RESET_OUT: assert property (state == ST_RESET |->
      charge_cmd == CHG_I_OFF && status == 3'h7) else $error("reset outputs");
   AST_PREQ_OUT: assert property (state == ST_PREQUAL |->
      charge_cmd inside {CHG_I_OFF, CHG_I_TWENTY}) else $error("prequal current");
   AST_FAST_OUT: assert property (state == ST_FAST |->
      charge_cmd inside {CHG_I_OFF, CHG_I_CC} && status == 3'h3) else $error("fast outputs");
   AST_FULL_OUT: assert property (state == ST_FULL |->
      charge_cmd inside {CHG_I_OFF, CHG_I_CV} && status == 3'h5) else $error("full outputs");
   AST_TOPOFF_OUT: assert property (state == ST_TOPOFF |->
      charge_cmd inside {CHG_I_OFF, CHG_I_CV} && status == 3'h7) else $error("topoff outputs");
   AST_STOP_OUT: assert property (state inside {ST_DONE, ST_FAULT} |->
      !charge_enable && status[2:1] == 2'h3) else $error("stopped outputs");
   AST_FAULT_HOLD: assert property (state == ST_FAULT && quiet_ff > 3'h4 |=>
      state == ST_FAULT) else $error("fault left");
   AST_OV_RESET: assert property (sense.battery_sense_above_ov |-> ##3 state == ST_RESET)
      else $error("overvoltage");
   AST_DIS_RESET: assert property (!charge_disable_n |-> ##3
      state == ST_RESET && !charge_enable) else $error("disable");
   AST_TEMP_PAUSE: assert property (!sense.temp_in_range |-> ##3 !charge_enable)
      else $error("temperature pause");
   AST_FAST_ENTRY: assert property (state == ST_FAST && $past(state) != ST_FAST |->
      $past(state) == ST_PREQUAL) else $error("fast entry");
   AST_FULL_ENTRY: assert property (state == ST_FULL && $past(state) != ST_FULL |->
      $past(state) == ST_FAST) else $error("full entry");
endmodule
bind chg_seq chg_seq_properties u_props (.clk(clk), .rst(rst),
   .charge_disable_n(charge_disable_n), .sense(sense), .charge_enable(charge_enable),
   .charge_cmd(charge_cmd), .status(status), .state(state));

/* File: tb/chg_analog.sv */
// Purpose: Comparator and power stage model for the sequencer
// Assumes: The bench sets the battery conditions to be seen
// Notes:   Low current shows only while voltage is held
`timescale 1ns/100ps
module chg_analog
   import chg_pkg::*;
(
   input  wire logic       clk,
   input  wire chg_sense_t level,
   input  wire chg_cmd_t   charge_cmd,
   output chg_sense_t      sense
);
   chg_sense_t sense_ff;
   chg_sense_t nxt_sense;
   // Current falls off only in constant-voltage charging
   always_comb begin
      nxt_sense = level;
      nxt_sense.current_below_tenth = level.current_below_tenth
                                    && charge_cmd == CHG_I_CV;
   end
   // Comparators settle one clock later
   always_ff @(posedge clk) sense_ff <= nxt_sense;
   assign sense = sense_ff;
endmodule

/* File: tb/chg_seq_test.sv */
// Purpose: Self-checking bench for the charge sequencer
// Assumes: Short ticks and phase limits set below
// Notes:   Each task starts from reset through the disable input
`timescale 1ns/100ps
module chg_seq_test
   import chg_pkg::*;
;
   localparam int PQ = 4;
   localparam int FT = 12;
   localparam int FU = 6;
   localparam int TO = 4;
   localparam chg_sense_t S_LOW = 7'h41;
   localparam chg_sense_t S_MID = 7'h61;
   localparam chg_sense_t S_REG = 7'h71;
   logic        clk;
   logic        rst;
   logic        charge_disable_n;
   chg_sense_t  level;
   chg_sense_t  sense;
   logic        charge_enable;
   chg_cmd_t    charge_cmd;
   chg_status_t status;
   chg_state_t  state;
   int          fail_count = 0;
   int          n_checks = 0;
   int          cyc = 0;
   chg_seq #(.TICK_CYCLES_P(4), .PREQUAL_TICKS(PQ), .FAST_TICKS(FT), .FULL_TICKS(FU),
      .TOPOFF_TICKS(TO)) u_dut (.clk(clk), .rst(rst), .charge_disable_n(charge_disable_n),
      .sense(sense), .charge_enable(charge_enable), .charge_cmd(charge_cmd),
      .status(status), .state(state));
   chg_analog u_ana (.clk(clk), .level(level), .charge_cmd(charge_cmd), .sense(sense));
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic drive(input chg_sense_t v, input logic dis_n);
      @(posedge clk);
      level <= v;
      charge_disable_n <= dis_n;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_st(input chg_state_t exp, input int lim);
      int i;
      i = 0;
      while (state !== exp && i < lim) begin
         step(1);
         i++;
      end
      check("state", state, exp);
   endtask
   // Disable, release, expect prequal at a twentieth of the current
   task automatic restart;
      drive(S_LOW, 1'b0);
      step(4);
      check("state", state, ST_RESET);
      drive(S_LOW, 1'b1);
      wait_st(ST_PREQUAL, 12);
      step(1);
      check("cmd", charge_cmd, CHG_I_TWENTY);
   endtask
   task automatic t_seq;
      restart();
      drive(S_MID, 1'b1);
      wait_st(ST_FAST, 10);
      drive(7'h60, 1'b1);
      step(80);
      check("state", state, ST_FAST);
      check("enable", charge_enable, 8'h00);
      check("status", status, 3'h3);
      drive(S_MID, 1'b1);
      step(5);
      check("cmd", charge_cmd, CHG_I_CC);
      drive(S_REG, 1'b1);
      wait_st(ST_FULL, 10);
      check("status", status, 3'h5);
      check("enable", charge_enable, 8'h01);
      drive(7'h73, 1'b1);
      wait_st(ST_TOPOFF, 10);
      wait_st(ST_DONE, 4 * TO + 10);
      step(20);
      check("state", state, ST_DONE);
      drive(7'h65, 1'b1);
      wait_st(ST_RESET, 10);
   endtask
   task automatic t_pq_fault;
      restart();
      drive(7'h40, 1'b1);
      step(40);
      check("state", state, ST_PREQUAL);
      drive(S_LOW, 1'b1);
      wait_st(ST_FAULT, 40);
      check("status", status, 3'h6);
      step(30);
      check("state", state, ST_FAULT);
   endtask
   task automatic t_fast_fault;
      restart();
      drive(S_MID, 1'b1);
      wait_st(ST_FAST, 10);
      step(4 * FU + 6);
      check("state", state, ST_FAST);
      wait_st(ST_FAULT, 4 * FT);
   endtask
   task automatic t_drop;
      restart();
      drive(S_MID, 1'b1);
      wait_st(ST_FAST, 10);
      drive(S_REG, 1'b1);
      wait_st(ST_FULL, 10);
      wait_st(ST_TOPOFF, 4 * FU + 10);
      drive(S_LOW, 1'b1);
      wait_st(ST_PREQUAL, 10);
      drive(7'h69, 1'b1);
      wait_st(ST_RESET, 10);
   endtask
   // Main sequence; the controller keeps the disable high to charge
   initial begin
      rst = 1'b1;
      charge_disable_n = 1'b1;
      level = S_LOW;
      step(16);
      check("state", state, ST_RESET);
      check("status", status, 3'h7);
      @(posedge clk);
      rst <= 1'b0;
      t_seq();
      t_pq_fault();
      t_fast_fault();
      t_drop();
      final_report();
   end
endmodule
